//--- logic/sms_map.svh
`ifndef SMS_MAP_SVH
`define SMS_MAP_SVH

// ----------------------------------------------------------------------
// register indices and byte addresses (byte address = 4 x index)
// ----------------------------------------------------------------------
`define SMS_IDX_DATA      8'h31
`define SMS_IDX_CTRL      8'h32
`define SMS_IDX_CSR       8'h33
`define SMS_ADDR_DATA     (8'(`SMS_IDX_DATA * 4))
`define SMS_ADDR_CTRL     (8'(`SMS_IDX_CTRL * 4))
`define SMS_ADDR_CSR      (8'(`SMS_IDX_CSR * 4))

// ----------------------------------------------------------------------
// serial_port_control fields
// ----------------------------------------------------------------------
`define SMS_CR_IE         7
`define SMS_CR_PE         6
`define SMS_CR_DIVEN      5
`define SMS_CR_MASTER_SELECT       4
`define SMS_CR_CLOCK_POLARITY       3
`define SMS_CR_CLOCK_PHASE       2
`define SMS_CR_RATE_HI    1
`define SMS_CR_RATE_LO    0
`define SMS_CR_RESET      8'h00

// ----------------------------------------------------------------------
// serial_port_control_status fields
// ----------------------------------------------------------------------
`define SMS_SR_TC         7
`define SMS_SR_WRITE_COLLISION_FLAG       6
`define SMS_SR_OVR        5
`define SMS_SR_MODE_FAULT_FLAG       4
`define SMS_SR_RSVD       3
`define SMS_SR_SOD        2
`define SMS_SR_SSM        1
`define SMS_SR_SSI        0

// ----------------------------------------------------------------------
// master sck half periods in pclk cycles, divide-by-two stage active
// ----------------------------------------------------------------------
`define SMS_HALF_DIV8     7'd4
`define SMS_HALF_DIV16    7'd8
`define SMS_HALF_DIV64    7'd32
`define SMS_HALF_DIV128   7'd64
`define SMS_EDGES_LAST    5'd15

`endif

//--- logic/sms_pkg.sv
package sms_pkg;

  // --------------------------------------------------------------------
  // pin groups
  // --------------------------------------------------------------------
  typedef struct packed {
    logic sck_i;
    logic mosi_i;
    logic miso_i;
    logic ss_n_i;
  } sms_pin_in_t;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } sms_pin_out_t;

  // --------------------------------------------------------------------
  // whole state of the port
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic       tc;
    logic       write_collision_flag;
    logic       overrun_flag;
    logic       mode_fault_flag;
    logic       output_disable;
    logic       software_select_mgmt;
    logic       internal_select_level;
    logic       tc_arm;
    logic       tc_rd;
    logic       write_collision_flag_arm;
    logic       mode_fault_flag_arm;
    logic [7:0] shift;
    logic       hold;
    logic [7:0] rxbuf;
    logic [4:0] edges;
    logic [6:0] divcnt;
    logic       mbusy;
    logic       sck;
    logic       sck_prev;
    logic [7:0] rdata;
    logic       slverr;
  } sms_state_t;

endpackage

//--- logic/sms_spi_port.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "sms_map.svh"
// Functional notes
// - master sck is pclk divided by 4, 8, 16, 32, 64 or 128 per rate bits.
// - divider_enable clear adds a divide-by-two; ignored with rate bits in slave.
// - master_select 1 drives sck and swaps miso/mosi; 0 is slave, sck input.
// - master seeing select low clears master_select by hardware.
// - clock_polarity sets sck idle level in master; slave counts sck edges of either sense.
// - clock_phase 0 captures on first edge, 1 on second edge.
// - each finished byte sets transfer_complete_flag, interrupt if enabled.
// - flag clears after status access then data read or write.
// - data writes ignored while flag set until status register read.
// - data write during transfer sets write_collision_flag, no interrupt.
// - byte done while flag set sets overrun_flag; status read clears it.
// - master with select low sets mode_fault_flag, interrupt if enabled.
// - mode fault clears after status access with flag set then control write.
// - output_disable releases data output; otherwise driven only when enabled.
// - software_select_mgmt ignores select pin, uses internal_select_level.
// - internal_select_level 0 selects, 1 deselects.
// - data write loads shift register; in master starts a transfer.
// - finished byte copied to receive buffer unless flag still set; data reads return buffer.
// - reset clears status register and control; status bit 3 stays zero.
// - port_enable connects pins; cleared by reset and master mode fault.
// - one interrupt request for complete, mode fault or overrun when enabled.
module sms_spi_port (
  // apb slave
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output      logic [31:0]          prdata,
  output      logic                 pready,
  output      logic                 pslverr,
  // serial pins
  input  wire sms_pkg::sms_pin_in_t pin_in,
  output      sms_pkg::sms_pin_out_t pin_out,
  // interrupt request
  output      logic                 irq
);

  sms_pkg::sms_state_t q;
  sms_pkg::sms_state_t d;

  // --------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------
  logic       acc;
  logic       wr;
  logic       rd;
  logic       hit_dr;
  logic       hit_cr;
  logic       hit_sr;
  logic       master;
  logic       en;
  logic       clock_phase;
  logic       ss_low;
  logic       fault;
  logic [6:0] half;
  logic       edge_ev;
  logic       last;
  logic       odd;
  logic       capture;
  logic       change;
  logic       rx_in;
  logic       busy;
  logic [7:0] rx_byte;

  assign acc    = psel & penable;
  assign wr     = acc & pwrite & pstrb[0];
  assign rd     = acc & ~pwrite;
  assign hit_dr = (paddr == `SMS_ADDR_DATA);
  assign hit_cr = (paddr == `SMS_ADDR_CTRL);
  assign hit_sr = (paddr == `SMS_ADDR_CSR);
  assign master = q.ctrl[`SMS_CR_MASTER_SELECT];
  assign en     = q.ctrl[`SMS_CR_PE];
  assign clock_phase   = q.ctrl[`SMS_CR_CLOCK_PHASE];
  // pin is left for general use under software select
  assign ss_low = q.software_select_mgmt ? ~q.internal_select_level : ~pin_in.ss_n_i;
  assign fault  = en & master & ss_low;
  assign busy   = q.mbusy | (q.edges != 5'd0);
  assign rx_in  = master ? pin_in.miso_i : pin_in.mosi_i;

  // --------------------------------------------------------------------
  // master rate
  // --------------------------------------------------------------------
  always_comb begin
    unique case (q.ctrl[`SMS_CR_RATE_HI:`SMS_CR_RATE_LO])
      2'b00:   half = `SMS_HALF_DIV8;
      2'b01:   half = `SMS_HALF_DIV16;
      2'b10:   half = `SMS_HALF_DIV64;
      2'b11:   half = `SMS_HALF_DIV128;
    endcase
    if (q.ctrl[`SMS_CR_DIVEN]) begin
      half = half >> 1;
    end
  end

  // --------------------------------------------------------------------
  // bit engine: 16 sck edges per byte, shared by master and slave
  // --------------------------------------------------------------------
  assign edge_ev = (q.mbusy & (q.divcnt == 7'd0)) |
                   (~master & en & ss_low & (pin_in.sck_i != q.sck_prev));
  assign last    = edge_ev & (q.edges == `SMS_EDGES_LAST);
  assign odd     = ~q.edges[0];
  assign capture = clock_phase ? ~odd : odd;
  assign change  = clock_phase ? (odd & (q.edges != 5'd0)) : ~odd;
  // with phase 1 the last capture and the last shift coincide
  assign rx_byte = clock_phase ? {q.shift[6:0], rx_in} : {q.shift[6:0], q.hold};

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb begin
    d          = q;
    d.sck_prev = pin_in.sck_i;

    // register read data is captured in the setup phase
    if (psel & ~penable) begin
      d.slverr = ~(hit_dr | hit_cr | hit_sr);
      d.rdata  = 8'h00;
      if (hit_dr) begin
        d.rdata = q.rxbuf;
      end else if (hit_cr) begin
        d.rdata = q.ctrl;
      end else if (hit_sr) begin
        d.rdata = {q.tc, q.write_collision_flag, q.overrun_flag, q.mode_fault_flag, 1'b0,
                   q.output_disable, q.software_select_mgmt, q.internal_select_level};
      end
    end

    // status register access arms the clearing sequences
    if ((rd | wr) & hit_sr) begin
      d.tc_arm = q.tc;
      if (q.mode_fault_flag) begin
        d.mode_fault_flag_arm = 1'b1;
      end
      if (rd) begin
        d.overrun_flag   = 1'b0;
        d.tc_rd = q.tc;
        if (q.write_collision_flag) begin
          d.write_collision_flag_arm = 1'b1;
        end
      end
      if (wr) begin
        d.output_disable = pwdata[`SMS_SR_SOD];
        d.software_select_mgmt = pwdata[`SMS_SR_SSM];
        d.internal_select_level = pwdata[`SMS_SR_SSI];
      end
    end

    // data register
    if ((rd | wr) & hit_dr) begin
      if (q.tc_arm) begin
        d.tc     = 1'b0;
        d.tc_arm = 1'b0;
        d.tc_rd  = 1'b0;
      end
      if (rd & q.write_collision_flag_arm) begin
        d.write_collision_flag     = 1'b0;
        d.write_collision_flag_arm = 1'b0;
      end
      if (wr) begin
        if (busy) begin
          d.write_collision_flag = 1'b1;
        end else if (~(q.tc & ~q.tc_rd)) begin
          d.shift = pwdata[7:0];
          d.hold  = 1'b0;
          if (master & en) begin
            d.mbusy  = 1'b1;
            d.divcnt = half - 7'd1;
            d.sck    = q.ctrl[`SMS_CR_CLOCK_POLARITY];
          end
        end
      end
    end

    // control register
    if (wr & hit_cr) begin
      d.ctrl = pwdata[7:0];
      if (q.mode_fault_flag_arm) begin
        d.mode_fault_flag     = 1'b0;
        d.mode_fault_flag_arm = 1'b0;
      end
    end

    // master sck generation
    if (q.mbusy) begin
      if (q.divcnt == 7'd0) begin
        d.divcnt = half - 7'd1;
        d.sck    = ~q.sck;
      end else begin
        d.divcnt = q.divcnt - 7'd1;
      end
    end else begin
      d.sck = q.ctrl[`SMS_CR_CLOCK_POLARITY];
    end

    // a slave drops a partial byte when deselected
    if (~master & ~(en & ss_low)) begin
      d.edges = 5'd0;
    end

    // disabling or leaving master mode aborts a master byte
    if (q.mbusy & ~(en & master)) begin
      d.mbusy = 1'b0;
      d.edges = 5'd0;
    end

    if (edge_ev) begin
      d.edges = q.edges + 5'd1;
      if (capture) begin
        d.hold = rx_in;
      end
      if (change) begin
        d.shift = {q.shift[6:0], q.hold};
      end
      if (last) begin
        d.shift = rx_byte;
        d.edges = 5'd0;
        d.mbusy = 1'b0;
        d.sck   = q.ctrl[`SMS_CR_CLOCK_POLARITY];
        d.tc    = 1'b1;
        if (q.tc) begin
          d.overrun_flag = 1'b1;
        end else begin
          d.rxbuf  = rx_byte;
          d.tc_arm = 1'b0;
          d.tc_rd  = 1'b0;
        end
      end
    end

    // mode fault wins over a simultaneous software clear
    if (fault) begin
      d.mode_fault_flag              = 1'b1;
      d.ctrl[`SMS_CR_MASTER_SELECT] = 1'b0;
      d.ctrl[`SMS_CR_PE]   = 1'b0;
      d.mbusy             = 1'b0;
      d.edges             = 5'd0;
      d.sck               = q.ctrl[`SMS_CR_CLOCK_POLARITY];
    end
  end

  // --------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign prdata  = {24'h000000, q.rdata};
  assign pready  = acc;
  assign pslverr = acc & q.slverr;

  assign irq = q.ctrl[`SMS_CR_IE] & (q.tc | q.mode_fault_flag | q.overrun_flag);

  always_comb begin
    pin_out.sck_o   = q.sck;
    pin_out.sck_oe  = en & master;
    pin_out.mosi_o  = q.shift[7];
    pin_out.mosi_oe = en & master & ~q.output_disable;
    pin_out.miso_o  = q.shift[7];
    pin_out.miso_oe = en & ~master & ss_low & ~q.output_disable;
  end

endmodule

//--- tb/sms_spi_slave_model.sv
`timescale 1ns/1ps
module sms_spi_slave_model (
  // serial side
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic       clock_phase,
  output      logic       miso,
  // bench side
  input  wire logic [7:0] tx_byte,
  output      logic [7:0] rx_byte
);
  logic [7:0] sh = 8'h00;
  logic       skip = 1'b0;
  initial rx_byte = 8'h00;
  // modes 0 and 3 only: capture on rising sck, change on falling sck
  always @(negedge sel_n) begin
    sh = tx_byte;
    skip = clock_phase;
  end
  always @(posedge sck) if (!sel_n) rx_byte = {rx_byte[6:0], mosi};
  // with phase 1 the msb already stands before the first transition
  always @(negedge sck) begin
    if (!sel_n) begin
      if (skip) skip = 1'b0;
      else sh = {sh[6:0], 1'b0};
    end
  end
  // a released line shows the inverse, so a stale level never passes
  assign miso = sel_n ? ~sh[7] : sh[7];
endmodule

//--- tb/sms_spi_port_assertions.sv
`timescale 1ns/1ps
`include "sms_map.svh"
module sms_spi_port_assertions (
  // apb
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic [7:0]            paddr,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // pins
  input wire sms_pkg::sms_pin_out_t pin_out,
  input wire logic                  irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic hit;
  assign acc = psel && penable;
  assign hit = paddr == `SMS_ADDR_DATA || paddr == `SMS_ADDR_CTRL
            || paddr == `SMS_ADDR_CSR;
  property p_rdy; acc |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no pready");
  property p_err; acc && !hit |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no slave error");
  property p_ok; acc && hit |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("false slave error");
  property p_excl; !(pin_out.mosi_oe && pin_out.miso_oe); endproperty
  a_excl: assert property (p_excl) else $error("both outputs on");
  property p_mosi; pin_out.mosi_oe |-> pin_out.sck_oe; endproperty
  a_mosi: assert property (p_mosi) else $error("mosi driven");
  property p_miso; pin_out.miso_oe |-> !pin_out.sck_oe; endproperty
  a_miso: assert property (p_miso) else $error("miso as master");
  property p_half;
    pin_out.sck_oe && $changed(pin_out.sck_o) |=> $stable(pin_out.sck_o);
  endproperty
  a_half: assert property (p_half) else $error("sck too fast");
  property p_rst; $rose(presetn) |-> !pin_out.sck_oe; endproperty
  a_rst: assert property (p_rst) else $error("sck on at reset");
  c_irq: cover property ($rose(irq));
  c_err: cover property (acc && pslverr);
  c_sck: cover property (pin_out.sck_oe && $rose(pin_out.sck_o));
endmodule

bind sms_spi_port sms_spi_port_assertions u_chk (.pclk, .presetn, .psel,
  .penable, .paddr, .pready, .pslverr, .pin_out, .irq);

//--- tb/tb_top.sv
`timescale 1ns/1ps
`include "sms_map.svh"
module tb_top;
  localparam logic [7:0] adat = `SMS_ADDR_DATA;
  localparam logic [7:0] actl = `SMS_ADDR_CTRL;
  localparam logic [7:0] acsr = `SMS_ADDR_CSR;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        ss_n = 1'b1;
  logic        sel_n = 1'b1;
  logic        ph = 1'b0;
  logic        miso;
  logic [7:0]  tx = 8'h00;
  logic [7:0]  rx;
  int          num_errors = 0;
  int          tests_run = 0;
  sms_pkg::sms_pin_in_t  pin_in;
  sms_pkg::sms_pin_out_t pin_out;
  always #5 pclk = ~pclk;
  assign pin_in = '{pin_out.sck_o, pin_out.mosi_o, miso, ss_n};
  sms_spi_port u_sms_spi_port (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb(4'h1), .prdata, .pready, .pslverr, .pin_in,
    .pin_out, .irq);
  sms_spi_slave_model u_sms_spi_slave_model (.sck(pin_out.sck_o),
    .mosi(pin_out.mosi_o), .sel_n, .clock_phase(ph), .miso, .tx_byte(tx),
    .rx_byte(rx));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic       e;
    apb(1'b0, a, 8'h00, q, e);
    chk({8'h00, q}, {8'h00, exp});
  endtask
  // the far side loads its reply byte when it is selected
  task automatic sel(input logic [7:0] b);
    #2 sel_n = 1'b1;
    tx = b;
    #1 sel_n = 1'b0;
  endtask
  task automatic wait_irq(output int n);
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      #1;
      n++;
    end
  endtask
  task automatic t_reset;
    logic [7:0] q;
    logic       e;
    rdc(actl, 8'h00);
    rdc(acsr, 8'h00);
    apb(1'b0, 8'h10, 8'h00, q, e);
    chk({15'h0, e}, 16'h1);
    wr(acsr, 8'hff);
    rdc(acsr, 8'h07);
    $display("reset test done");
  endtask
  task automatic t_rates;
    logic [7:0] cr [6] = '{8'hf0, 8'hd0, 8'hd1, 8'hf2, 8'hd2, 8'hd3};
    int n;
    wr(acsr, 8'h03);
    for (int i = 0; i < 6; i++) begin
      sel(8'h96 + 8'(i));
      wr(actl, cr[i]);
      wr(adat, 8'h5a - 8'(i));
      wait_irq(n);
      chk(16'(n), 16'(32 << i));
      chk({15'h0, irq}, 16'h1);
      rdc(acsr, 8'h83);
      rdc(adat, 8'h96 + 8'(i));
      chk({8'h00, rx}, {8'h00, 8'h5a - 8'(i)});
    end
    rdc(acsr, 8'h03);
    $display("rate test done");
  endtask
  task automatic t_write_collision_flag;
    int n;
    wr(actl, 8'hf0);
    wr(acsr, 8'h07);
    #1 chk({15'h0, pin_out.mosi_oe}, 16'h0);
    wr(acsr, 8'h03);
    #1 chk({15'h0, pin_out.mosi_oe}, 16'h1);
    sel(8'h5e);
    wr(adat, 8'hc3);
    wr(adat, 8'h00);
    wait_irq(n);
    wr(adat, 8'h77);
    repeat (40) @(posedge pclk);
    chk({8'h00, rx}, 16'h00c3);
    rdc(acsr, 8'hc3);
    rdc(adat, 8'h5e);
    rdc(acsr, 8'h03);
    $display("collision test done");
  endtask
  task automatic t_mode3;
    int n;
    wr(actl, 8'ha0);
    wr(actl, 8'hbc);
    @(posedge pclk);
    #1 chk({15'h0, pin_out.sck_o}, 16'h1);
    wr(actl, 8'hfc);
    ph = 1'b1;
    sel(8'h3c);
    wr(adat, 8'hb4);
    wait_irq(n);
    chk(16'(n), 16'd32);
    rdc(acsr, 8'h83);
    rdc(adat, 8'h3c);
    chk({8'h00, rx}, 16'h00b4);
    wr(actl, 8'ha0);
    wr(actl, 8'hf0);
    ph = 1'b0;
    $display("phase test done");
  endtask
  task automatic t_mode_fault_flag;
    wr(acsr, 8'h00);
    ss_n <= 1'b0;
    repeat (4) @(posedge pclk);
    #1 chk({15'h0, irq}, 16'h1);
    chk({15'h0, pin_out.sck_oe}, 16'h0);
    rdc(actl, 8'ha0);
    rdc(acsr, 8'h10);
    wr(actl, 8'h80);
    rdc(acsr, 8'h00);
    ss_n <= 1'b1;
    $display("fault test done");
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #100us;
    num_errors++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rates();
    t_write_collision_flag();
    t_mode3();
    t_mode_fault_flag();
    close_out();
  end
endmodule
